// ### hdl/ohg_consts.vh
// timing counts, codes and state encodings for the overcurrent hiccup guard
// assumes a single 200 MHz clock; included by its bare name
`ifndef OHG_CONSTS_VH
`define OHG_CONSTS_VH

// ----------------------------------------------------------------------------
// clock and time conversion
// ----------------------------------------------------------------------------
`define OHG_CLK_MHZ 200
// least time in ns to whole cycles, rounded up
`define OHG_CYC_UP(ns) ((((ns) * `OHG_CLK_MHZ) + 999) / 1000)
// longest time in ns to whole cycles, rounded down
`define OHG_CYC_DN(ns) (((ns) * `OHG_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------------
// times, in ns, and the soft-start step count
// ----------------------------------------------------------------------------
`define OHG_POR_DELAY_NS 6800000
`define OHG_SS_TOTAL_NS 6800000
`define OHG_SS_STEPS 64
`define OHG_SS_STEP_NS (`OHG_SS_TOTAL_NS / `OHG_SS_STEPS)
`define OHG_SAMPLE_STEP_NS 35800
`define OHG_BLANK_NS 200
`define OHG_MIN_LOW_NS 425

// ----------------------------------------------------------------------------
// short cycle counts at the clock width of their counters
// ----------------------------------------------------------------------------
`define OHG_BLANK_CYC 7'h28
`define OHG_MIN_LOW_CYC 7'h55
`define OHG_SS_LAST_STEP 6'h3F

// ----------------------------------------------------------------------------
// long cycle counts of the times above, at the 21-bit timer width
// ----------------------------------------------------------------------------
`define OHG_POR_DELAY_CYC 21'h14C080
`define OHG_SS_STEP_CYC 21'h05302
`define OHG_SAMPLE_STEP_CYC 21'h01BF8

// ----------------------------------------------------------------------------
// hiccup and narrow-pulse counts
// ----------------------------------------------------------------------------
`define OHG_DUMMY_COUNT 2'h2
`define OHG_NARROW_LIMIT 2'h2

// ----------------------------------------------------------------------------
// set point codes: one lsb is 2.5 mV at the sense pin, 5 mV doubled
// ----------------------------------------------------------------------------
`define OHG_CODE_LSB_UV 2500
`define OHG_RANGE_MAX_CODE 8'h5F
`define OHG_DISABLE_CODE 8'h78
`define OHG_CODE_RESET 8'h00

// ----------------------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------------------
`define OHG_ST_OFF 3'h0
`define OHG_ST_DELAY 3'h1
`define OHG_ST_SAMPLE 3'h2
`define OHG_ST_RAMP 3'h3
`define OHG_ST_RUN 3'h4
`define OHG_ST_DUMMY 3'h5

`endif

// ### hdl/ohg_sync.v
// two-flop level synchroniser, one per bit of the bus
// assumes the inputs are asynchronous levels; the first flop feeds only the second
`timescale 1ns/1ps

module ohg_sync #(
  parameter WIDTH = 4
) (
  input wire clk_in,                 // destination clock
  input wire rst_in,                 // synchronous reset, active high
  input wire [WIDTH-1:0] async_in,   // asynchronous levels
  output reg [WIDTH-1:0] sync_out    // synchronised levels
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### hdl/ohg_guard.v
// overcurrent hiccup guard: set point sampling, blanked low-side monitoring,
// narrow-pulse stretching and the dummy/real soft-start retry sequencer
// assumes pwm requests and the cycle strobe come from logic on ref_clk_in;
// bias, enable and both comparators are asynchronous analog levels
//
// Contract
// R1: on trip, gates off at once, then two dummy time-outs and one real ramp
// R2: hiccup retries repeat forever while the short remains; no retry limit
// R3: after power-on and the start-up delay, sample trip level before any ramp
// R4: while sampling, low gate off, sense current on, level held in counter/dac
// R5: set point kept while biased; replaced only by a sample leaving shutdown
// R6: compare low-side drop only after blanking from the low-gate rising edge
// R7: window closes when low gate drops; trip anywhere inside the open window
// R8: after two narrow or missing low pulses, third is stretched or inserted
// R9: when protection is found disabled, pulse stretching and insertion are off
// R10: trip reference is twice the voltage sampled on the program resistor
// R11: sample above disable threshold, or no resistor, disables protection
// R12: sampling resolves doubled levels from 0 mV up to 475 mV
// R13: trip during a real ramp shuts output and restarts two dummy time-outs
// R14: hiccup period spans two ramp times up to three, per trip moment
// R15: trip detection active in every soft-start; start into short is a retry
// R16: with short removed, the next real ramp completes and hiccup ends
// R17: no resampling in retries; only disable then enable resamples
// R18: enable low stops oscillator, holds both gates low, re-arms soft-start
// R19: soft-start reference ramps in 64 discrete digital steps
// R20: each dummy time-out lasts a full soft-start with both gates low
`timescale 1ns/1ps
`include "ohg_consts.vh"

module ohg_guard #(
  parameter [20:0] POR_DELAY_CYC = `OHG_POR_DELAY_CYC,
  parameter [20:0] SS_STEP_CYC = `OHG_SS_STEP_CYC,
  parameter [20:0] SAMPLE_STEP_CYC = `OHG_SAMPLE_STEP_CYC
) (
  input wire ref_clk_in,             // 200 MHz internal timebase
  input wire sys_rst_in,             // synchronous reset, active high
  input wire bias_ok_in,             // bias above power-on threshold, async
  input wire enable_in,              // enable pin above disable threshold, async
  input wire trip_cmp_in,            // switch_node drop at or above trip_ref, async
  input wire sample_cmp_in,          // sample dac at or above trip_sense_pin, async
  input wire pwm_low_req_in,         // internal pwm low-side request
  input wire pwm_high_req_in,        // internal pwm high-side request
  input wire pwm_cycle_in,           // one-cycle strobe at each switching cycle start
  output reg low_side_gate_out,      // low-side gate drive
  output reg high_side_gate_out,     // high-side gate drive
  output reg sense_current_out,      // trip_sense_current source enable
  output reg [7:0] sample_dac_out,   // live sample-and-hold dac code
  output reg [8:0] trip_ref_out,     // trip reference, twice the held code, clamped at twice 8'h5F
  output reg guard_disabled_out,     // overcurrent_guard found disabled
  output reg [5:0] ss_step_out,      // soft-start reference step
  output reg osc_run_out,            // oscillator run
  output reg amp_enable_out,         // error amplifier enabled
  output reg hiccup_out,             // in hiccup retry
  output reg trip_pulse_out          // one-cycle pulse per trip
);

  localparam [6:0] BLANK_CYC = `OHG_BLANK_CYC;
  localparam [6:0] MIN_LOW_CYC = `OHG_MIN_LOW_CYC;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  wire [3:0] sync_w;
  wire bias_s;
  wire en_s;
  wire trip_s;
  wire smp_s;

  ohg_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .async_in({bias_ok_in, enable_in, trip_cmp_in, sample_cmp_in}),
    .sync_out(sync_w)
  );

  assign bias_s = sync_w[3];
  assign en_s = sync_w[2];
  assign trip_s = sync_w[1];
  assign smp_s = sync_w[0];

  // --------------------------------------------------------------------------
  // state declarations
  // --------------------------------------------------------------------------
  reg [2:0] state_q;
  reg [20:0] timer_q;
  reg [5:0] step_q;
  reg [1:0] dummy_q;
  reg [7:0] code_q;
  reg guard_off_q;
  reg hiccup_q;
  reg low_prev_q;
  reg low_req_prev_q;
  reg [6:0] blank_q;
  reg win_open_q;
  reg [6:0] width_q;
  reg [1:0] narrow_q;
  reg force_q;
  reg force_done_q;
  reg [6:0] force_cnt_q;

  wire enabled = bias_s & en_s;
  wire gates_live = (state_q == `OHG_ST_RAMP) | (state_q == `OHG_ST_RUN);
  wire step_end = (timer_q == SS_STEP_CYC - 21'h000001);
  // a trip only counts inside an open, blanked window while switching
  wire trip_evt = gates_live & win_open_q & trip_s & ~guard_off_q; // R7 R15
  wire low_drive = gates_live & (pwm_low_req_in | force_q);
  wire high_drive = gates_live & pwm_high_req_in & ~low_drive;
  wire low_rise = low_drive & ~low_prev_q;
  wire req_rise = pwm_low_req_in & ~low_req_prev_q;
  wire stretch_armed = (narrow_q == `OHG_NARROW_LIMIT) & ~guard_off_q & gates_live; // R9
  wire narrow_now = (width_q < MIN_LOW_CYC);
  wire insert_now = stretch_armed & ~force_done_q & pwm_cycle_in & (width_q == 7'h00);
  wire stretch_now = stretch_armed & ~force_done_q & req_rise;

  // --------------------------------------------------------------------------
  // sequencer: delay, sample, ramp, run and hiccup
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= `OHG_ST_OFF;
      timer_q <= 21'h000000;
      step_q <= 6'h00;
      dummy_q <= 2'h0;
      code_q <= `OHG_CODE_RESET;
      guard_off_q <= 1'b0;
      hiccup_q <= 1'b0;
    end else if (!enabled) begin
      // shutdown re-arms everything but keeps the held set point and guard_off_q
      state_q <= `OHG_ST_OFF; // R18
      timer_q <= 21'h000000;
      step_q <= 6'h00;
      dummy_q <= 2'h0;
      hiccup_q <= 1'b0;
    end else begin
      case (state_q)
        `OHG_ST_OFF: begin
          // leaving shutdown is the only way into a fresh sample
          state_q <= `OHG_ST_DELAY; // R5 R17
          timer_q <= 21'h000000;
          code_q <= `OHG_CODE_RESET;
        end
        `OHG_ST_DELAY: begin
          if (timer_q == POR_DELAY_CYC - 21'h000001) begin
            state_q <= `OHG_ST_SAMPLE; // R3
            timer_q <= 21'h000000;
          end else begin
            timer_q <= timer_q + 21'h000001;
          end
        end
        `OHG_ST_SAMPLE: begin
          if (smp_s) begin
            // dac has caught up with the pin: hold this code
            state_q <= `OHG_ST_RAMP; // R4
            guard_off_q <= 1'b0;
            timer_q <= 21'h000000;
            step_q <= 6'h00;
          end else if (code_q == `OHG_DISABLE_CODE) begin
            state_q <= `OHG_ST_RAMP; // R11
            guard_off_q <= 1'b1;
            timer_q <= 21'h000000;
            step_q <= 6'h00;
          end else if (timer_q == SAMPLE_STEP_CYC - 21'h000001) begin
            code_q <= code_q + 8'h01; // R12
            timer_q <= 21'h000000;
          end else begin
            timer_q <= timer_q + 21'h000001;
          end
        end
        `OHG_ST_RAMP: begin
          if (trip_evt) begin
            state_q <= `OHG_ST_DUMMY; // R1 R13
            dummy_q <= `OHG_DUMMY_COUNT;
            timer_q <= 21'h000000;
            step_q <= 6'h00;
            hiccup_q <= 1'b1;
          end else if (step_end) begin
            timer_q <= 21'h000000;
            if (step_q == `OHG_SS_LAST_STEP) begin
              state_q <= `OHG_ST_RUN; // R16
              hiccup_q <= 1'b0;
            end else begin
              step_q <= step_q + 6'h01; // R19
            end
          end else begin
            timer_q <= timer_q + 21'h000001;
          end
        end
        `OHG_ST_RUN: begin
          if (trip_evt) begin
            state_q <= `OHG_ST_DUMMY; // R1
            dummy_q <= `OHG_DUMMY_COUNT;
            timer_q <= 21'h000000;
            step_q <= 6'h00;
            hiccup_q <= 1'b1;
          end
        end
        `OHG_ST_DUMMY: begin
          // a dummy is a full ramp's worth of steps with the gates held low
          if (step_end) begin
            timer_q <= 21'h000000;
            if (step_q == `OHG_SS_LAST_STEP) begin
              step_q <= 6'h00;
              if (dummy_q == 2'h1) begin
                // no retry counter: every hiccup ends in another real ramp
                state_q <= `OHG_ST_RAMP; // R2 R14
                dummy_q <= 2'h0;
              end else begin
                dummy_q <= dummy_q - 2'h1;
              end
            end else begin
              step_q <= step_q + 6'h01; // R20
            end
          end else begin
            timer_q <= timer_q + 21'h000001;
          end
        end
        default: begin
          state_q <= `OHG_ST_OFF;
          timer_q <= 21'h000000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // blanked monitoring window
  // --------------------------------------------------------------------------
  // the window follows the internal drive, so a stretched pulse is monitored too
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      low_prev_q <= 1'b0;
      blank_q <= 7'h00;
      win_open_q <= 1'b0;
    end else begin
      low_prev_q <= low_drive;
      if (!low_drive || trip_evt) begin
        win_open_q <= 1'b0; // R7
        blank_q <= 7'h00;
      end else if (low_rise) begin
        blank_q <= 7'h01; // R6
        win_open_q <= 1'b0;
      end else if (!win_open_q) begin
        if (blank_q == BLANK_CYC) begin
          win_open_q <= 1'b1; // R6
        end else begin
          blank_q <= blank_q + 7'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // narrow low-side pulse stretch and insertion
  // --------------------------------------------------------------------------
  // a missing pulse is inserted at the end strobe of the third cycle, which
  // shifts it by one edge into the fourth cycle, so monitoring comes every fourth cycle
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      low_req_prev_q <= 1'b0;
      width_q <= 7'h00;
      narrow_q <= 2'h0;
      force_q <= 1'b0;
      force_done_q <= 1'b0;
      force_cnt_q <= 7'h00;
    end else begin
      low_req_prev_q <= pwm_low_req_in;
      if (!gates_live) begin
        width_q <= 7'h00;
        narrow_q <= 2'h0;
        force_q <= 1'b0;
        force_done_q <= 1'b0;
        force_cnt_q <= 7'h00;
      end else begin
        if (pwm_cycle_in) begin
          width_q <= {6'h00, low_drive};
          force_done_q <= 1'b0;
          if (insert_now) begin
            narrow_q <= 2'h0;
          end else if (narrow_now && !guard_off_q) begin
            if (narrow_q != `OHG_NARROW_LIMIT) begin
              narrow_q <= narrow_q + 2'h1; // R8
            end
          end else begin
            narrow_q <= 2'h0;
          end
        end else if (low_drive && width_q != MIN_LOW_CYC) begin
          width_q <= width_q + 7'h01;
        end
        if (stretch_now || insert_now) begin
          force_q <= 1'b1; // R8
          force_done_q <= 1'b1;
          force_cnt_q <= 7'h01;
        end else if (force_q) begin
          if (force_cnt_q == MIN_LOW_CYC) begin
            force_q <= 1'b0;
          end else begin
            force_cnt_q <= force_cnt_q + 7'h01;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      low_side_gate_out <= 1'b0;
      high_side_gate_out <= 1'b0;
      sense_current_out <= 1'b0;
      sample_dac_out <= 8'h00;
      trip_ref_out <= 9'h000;
      guard_disabled_out <= 1'b0;
      ss_step_out <= 6'h00;
      osc_run_out <= 1'b0;
      amp_enable_out <= 1'b0;
      hiccup_out <= 1'b0;
      trip_pulse_out <= 1'b0;
    end else begin
      // a trip drops both gates in the same edge that leaves the ramp or run state
      low_side_gate_out <= low_drive & ~trip_evt & enabled; // R1 R18
      high_side_gate_out <= high_drive & ~trip_evt & enabled; // R1 R18
      sense_current_out <= enabled & ((state_q == `OHG_ST_DELAY) |
                                      (state_q == `OHG_ST_SAMPLE)); // R4
      sample_dac_out <= code_q;
      if (code_q > `OHG_RANGE_MAX_CODE) begin
        trip_ref_out <= {`OHG_RANGE_MAX_CODE, 1'b0}; // R12
      end else begin
        trip_ref_out <= {code_q, 1'b0}; // R10
      end
      guard_disabled_out <= guard_off_q;
      if (state_q == `OHG_ST_RUN) begin
        ss_step_out <= `OHG_SS_LAST_STEP;
      end else if (state_q == `OHG_ST_RAMP) begin
        ss_step_out <= step_q; // R19
      end else begin
        ss_step_out <= 6'h00;
      end
      osc_run_out <= enabled; // R18
      amp_enable_out <= gates_live & ~trip_evt & enabled;
      hiccup_out <= hiccup_q;
      trip_pulse_out <= trip_evt;
    end
  end

endmodule

// ### test/ohg_fet_model.sv
// behavioural model of the external fets and the trip programming resistor
// assumes the guard's outputs drive it; comparator outputs are async levels
`timescale 1ns/1ps

module ohg_fet_model (
  input logic sense_current_in,  // sense source into the resistor
  input logic [7:0] sample_dac_in, // live sample code
  input logic low_side_gate_in,  // low-side fet gate
  input logic [8:0] trip_ref_in, // trip reference code
  input logic res_fitted_in,     // resistor present
  input logic [7:0] res_code_in, // resistor voltage code
  input logic short_in,          // output shorted
  output logic sample_cmp_out,   // dac at or above pin
  output logic trip_cmp_out      // drop at or above reference
);
  // an open pin floats to the rail, so the dac never reaches it
  wire [7:0] pin_code = res_fitted_in ? res_code_in : 8'hFF;
  // a short pegs the drop at full scale; normal load stays well below any trip
  wire [8:0] drop_code = short_in ? 9'h1FF : 9'h004;
  assign sample_cmp_out = sense_current_in && (sample_dac_in >= pin_code);
  assign trip_cmp_out = low_side_gate_in && (drop_code >= trip_ref_in);
endmodule

// ### test/ohg_guard_props.sv
// assertion checker for the overcurrent hiccup guard, bound to its top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module ohg_guard_props #(
  parameter [20:0] POR_DELAY_CYC = 21'h14,
  parameter [20:0] SS_STEP_CYC = 21'h8,
  parameter [20:0] SAMPLE_STEP_CYC = 21'h4
) (
  input logic ref_clk_in,           // clock
  input logic sys_rst_in,           // reset
  input logic low_side_gate_out,    // low gate
  input logic high_side_gate_out,   // high gate
  input logic sense_current_out,    // sense source
  input logic [7:0] sample_dac_out, // set point code
  input logic [8:0] trip_ref_out,   // trip reference
  input logic [5:0] ss_step_out,    // ramp step
  input logic osc_run_out,          // oscillator run
  input logic amp_enable_out,       // amplifier on
  input logic hiccup_out,           // retry mode
  input logic trip_pulse_out        // trip strobe
);
  localparam int DUMMY_CYC = 128 * SS_STEP_CYC;
  logic [21:0] idle_q;
  logic [7:0] low_on_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || amp_enable_out) idle_q <= 22'h0;
    else idle_q <= idle_q + 22'h1;
    if (!low_side_gate_out) low_on_q <= 8'h00;
    else if (low_on_q != 8'hFF) low_on_q <= low_on_q + 8'h01;
  end
  sequence s_trip; trip_pulse_out; endsequence
  sequence s_gates_off; !low_side_gate_out && !high_side_gate_out; endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  chk_trip_gates_off: assert property (s_trip |-> s_gates_off ##1 s_gates_off [*8])
    else $error("gates not off after trip");
  chk_trip_single: assert property (s_trip |=> !trip_pulse_out)
    else $error("trip strobe longer than one cycle");
  // two full dummy time-outs, small slack for register stages
  chk_dummy_length: assert property ($rose(amp_enable_out) && hiccup_out |->
    idle_q >= DUMMY_CYC - 4 && idle_q <= DUMMY_CYC + 4) else $error("dummy time-out length");
  chk_window_blank: assert property (s_trip |-> low_on_q >= 8'h24)
    else $error("trip outside blanked window");
  chk_sense_gate_off: assert property (sense_current_out |-> s_gates_off)
    else $error("gate on while sampling");
  chk_ref_doubled: assert property (amp_enable_out && $past(amp_enable_out) |->
    trip_ref_out == (sample_dac_out > 8'h5F ? 9'h0BE : {sample_dac_out, 1'h0}))
    else $error("trip reference not doubled");
  chk_step_ramp: assert property (ss_step_out != $past(ss_step_out) |->
    ss_step_out == $past(ss_step_out) + 6'h01 || ss_step_out == 6'h00)
    else $error("soft-start step jump");
  chk_shutdown_quiet: assert property (!osc_run_out [*2] |->
    !low_side_gate_out && !high_side_gate_out && !amp_enable_out)
    else $error("activity while shut down");
  chk_retry_no_sample: assert property ($rose(amp_enable_out) && hiccup_out |->
    !$past(sense_current_out)) else $error("resample during retry");
  chk_first_sampled: assert property ($rose(amp_enable_out) && !hiccup_out |->
    $past(sense_current_out)) else $error("ramp without sampling");
  // a shutdown also clears hiccup, with the step at zero
  chk_hiccup_done: assert property ($fell(hiccup_out) && osc_run_out |-> ss_step_out == 6'h3F)
    else $error("hiccup left before ramp end");
endmodule

bind ohg_guard ohg_guard_props #(
  .POR_DELAY_CYC(POR_DELAY_CYC), .SS_STEP_CYC(SS_STEP_CYC), .SAMPLE_STEP_CYC(SAMPLE_STEP_CYC)
) u_props (.ref_clk_in, .sys_rst_in, .low_side_gate_out, .high_side_gate_out,
  .sense_current_out, .sample_dac_out, .trip_ref_out, .ss_step_out, .osc_run_out,
  .amp_enable_out, .hiccup_out, .trip_pulse_out);

// ### test/ohg_guard_tb.sv
// self-checking bench for the overcurrent hiccup guard with a fet model
// assumes the guard, its synchroniser, the model and the checker are compiled
`timescale 1ns/1ps

module ohg_guard_tb;
  logic ref_clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic bias_ok_in = 1'h0;
  logic enable_in = 1'h0;
  logic pwm_low_req_in = 1'h0;
  logic pwm_high_req_in = 1'h0;
  logic pwm_cycle_in = 1'h0;
  logic res_fitted = 1'h1;
  logic short_on = 1'h0;
  logic [7:0] res_code = 8'h20;
  wire trip_cmp_in, sample_cmp_in, low_side_gate_out, high_side_gate_out, sense_current_out;
  wire guard_disabled_out, osc_run_out, amp_enable_out, hiccup_out, trip_pulse_out;
  wire [7:0] sample_dac_out;
  wire [8:0] trip_ref_out;
  wire [5:0] ss_step_out;
  int seed = 37945;
  int checked = 0;
  int n_mismatch = 0;
  int pcnt = 0;
  int lw = 100;
  int wcnt = 0;
  int n_wide = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  ohg_guard #(.POR_DELAY_CYC(21'h14), .SS_STEP_CYC(21'h8), .SAMPLE_STEP_CYC(21'h4)) dut_u (
    .ref_clk_in, .sys_rst_in, .bias_ok_in, .enable_in, .trip_cmp_in, .sample_cmp_in,
    .pwm_low_req_in, .pwm_high_req_in, .pwm_cycle_in, .low_side_gate_out, .high_side_gate_out,
    .sense_current_out, .sample_dac_out, .trip_ref_out, .guard_disabled_out, .ss_step_out,
    .osc_run_out, .amp_enable_out, .hiccup_out, .trip_pulse_out);
  ohg_fet_model fet_u (.sense_current_in(sense_current_out), .sample_dac_in(sample_dac_out),
    .low_side_gate_in(low_side_gate_out), .trip_ref_in(trip_ref_out),
    .res_fitted_in(res_fitted), .res_code_in(res_code), .short_in(short_on),
    .sample_cmp_out(sample_cmp_in), .trip_cmp_out(trip_cmp_in));

  // ---------------------------------------------------------------
  // 120-cycle pwm frame, low request of lw cycles at its end
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    pcnt <= (pcnt == 119) ? 0 : pcnt + 1;
    pwm_cycle_in <= (pcnt == 119);
    pwm_low_req_in <= (lw > 0) && (pcnt >= 119 - lw) && (pcnt < 119);
    pwm_high_req_in <= (pcnt >= 2) && (pcnt < 117 - lw);
    if (low_side_gate_out) wcnt <= wcnt + 1;
    else begin
      if (wcnt >= 85) n_wide <= n_wide + 1;
      wcnt <= 0;
    end
  end

  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_in(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  function automatic logic pick(input int which);
    case (which)
      0: return amp_enable_out;
      1: return ss_step_out == 6'h3F;
      2: return hiccup_out;
      default: return trip_pulse_out;
    endcase
  endfunction
  // bounded wait on a design flag, leaves the bench just after an edge
  task automatic wait_flag(input int which, input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (pick(which) !== lvl && n < lim) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    cmp_in("flag wait", 0, lim - 1, n);
  endtask
  task automatic power(input logic lvl, input logic fitted);
    @(posedge ref_clk_in);
    bias_ok_in <= 1'h1;
    enable_in <= lvl;
    res_fitted <= fitted;
    res_code <= 8'h08 + 8'({$random(seed)} % 88);
  endtask
  task automatic wide_count(input int lo, input int hi);
    int k;
    // let a pulse of the previous width run out before counting
    repeat (120) @(posedge ref_clk_in);
    k = n_wide;
    repeat (1080) @(posedge ref_clk_in);
    #1;
    cmp_in("wide pulses", lo, hi, n_wide - k);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int n;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'h0;
    power(1'h1, 1'h1);
    wait_flag(0, 1'h1, 1000, n);
    cmp("set point", {1'h0, res_code}, {1'h0, sample_dac_out});
    cmp("trip ref", {res_code, 1'h0}, trip_ref_out);
    cmp("guard off", 9'h0, {8'h0, guard_disabled_out});
    wait_flag(1, 1'h1, 1000, n);
    cmp_in("ramp cycles", 500, 508, n);
    lw = 20;
    wide_count(2, 4);
    lw = 0;
    wide_count(2, 4);
    lw = 90 + {$random(seed)} % 20;
    wide_count(8, 10);
    cmp("no trip", 9'h0, {8'h0, hiccup_out});
    power(1'h0, 1'h0);
    repeat (8) @(posedge ref_clk_in);
    #1;
    cmp("shutdown", 9'h0, {5'h0, low_side_gate_out, high_side_gate_out, osc_run_out,
      amp_enable_out});
    power(1'h1, 1'h0);
    wait_flag(0, 1'h1, 1000, n);
    cmp("open code", 9'h078, {1'h0, sample_dac_out});
    cmp("guard off", 9'h001, {8'h0, guard_disabled_out});
    cmp("clamped ref", 9'h0BE, trip_ref_out);
    lw = 20;
    short_on = 1'h1;
    wide_count(0, 0);
    cmp("no trip", 9'h0, {8'h0, hiccup_out});
    power(1'h0, 1'h1);
    repeat (8) @(posedge ref_clk_in);
    power(1'h1, 1'h1);
    wait_flag(0, 1'h1, 1000, n);
    cmp("new set point", {1'h0, res_code}, {1'h0, sample_dac_out});
    lw = 60;
    wait_flag(3, 1'h1, 400, n);
    @(posedge ref_clk_in);
    #1;
    cmp("hiccup", 9'h001, {8'h0, hiccup_out});
    repeat (2) begin
      wait_flag(3, 1'h0, 10, n);
      wait_flag(3, 1'h1, 2000, n);
      cmp_in("hiccup period", 1020, 1320, n);
    end
    short_on = 1'h0;
    wait_flag(2, 1'h0, 3000, n);
    cmp("ramp end", 9'h03F, {3'h0, ss_step_out});
    summarize();
  end

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    n_mismatch++;
    summarize();
  end
endmodule
